/* hw/aux_pkg.sv */
// package for the aux channel controller: register map, field layout, timing counts
// assumes a 100 MHz core clock and a 32-bit apb register bus
package aux_pkg;
   localparam int unsigned ClkMhz = 100;
   localparam logic [11:0] OffCtl = 12'h000;
   localparam logic [11:0] OffData0 = 12'h004;
   localparam logic [11:0] OffPwrFw = 12'h018;
   localparam logic [11:0] OffPwrDrv = 12'h01c;
   localparam logic [11:0] OffPwrStat = 12'h020;
   localparam logic [11:0] OffLowPwr = 12'h024;
   localparam int unsigned NumData = 5;
   localparam int unsigned BitBusy = 31;
   localparam int unsigned BitDone = 30;
   localparam int unsigned BitRxErr = 25;
   localparam int unsigned BitRoute = 24;
   localparam int unsigned BitIrqEn = 29;
   localparam int unsigned TmoLsb = 26;
   localparam int unsigned BitHealth = 15;
   localparam int unsigned TimeoutUs0 = 400;
   localparam int unsigned TimeoutUs1 = 600;
   localparam int unsigned TimeoutUs2 = 800;
   localparam int unsigned TimeoutUs3 = 4000;
   localparam int unsigned PwrUpUs = 2;
   localparam int unsigned PwrUpCycles = PwrUpUs * ClkMhz;
   localparam logic [31:0] CtlReset = 32'h0000_0000;
endpackage

/* hw/aux_pwr_if.sv */
// carrier between the top and the io power sequencer
// assumes both ends share clk and rst_n
`timescale 1ns/1ps
interface aux_pwr_if;
   logic request;
   logic powered;
   modport ctrl (output request, input powered);
   modport seq (input request, output powered);
endinterface

/* hw/aux_pwr_seq.sv */
// aux io power sequencer: or of all requesters, fixed ramp delay to the power state
// assumes the io well settles within the ramp count
`timescale 1ns/1ps
module aux_pwr_seq
   import aux_pkg::*;
#(
   parameter int unsigned RampCycles = PwrUpCycles
) (
   input wire logic clk,
   input wire logic rst_n,
   aux_pwr_if.seq pwr
);
   logic [15:0] cnt_q, cnt_d;
   logic on_q, on_d;
   always_comb begin
      cnt_d = cnt_q;
      on_d = on_q;
      if (!pwr.request) begin
         cnt_d = 16'h0000;
         on_d = 1'b0;
      end else if (!on_q) begin
         if (cnt_q == 16'(RampCycles - 1)) begin
            on_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         on_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         on_q <= on_d;
      end
   end
   assign pwr.powered = on_q;
endmodule

/* hw/aux_channel_controller.sv */
// aux channel controller: apb registers, io power requests, one transaction at a time
// assumes an already powered display; the aux link phy sits outside behind a start/reply handshake
//
// Summary of operation
// - power request 1b, state reads 1b
// - two independent power request registers
// - deep low-power select bit drives deepLowPowerAllowed only; power wells stay as requested
// - timeout codes 400/600/800/4000 us
// - bit 31 starts, reads as busy
// - completion reads 01 in bits 31:30
// - bit 25 receive error, write-one clears
// - routing field selects tunnel or native
`timescale 1ns/1ps
module aux_channel_controller
   import aux_pkg::*;
#(
   parameter int unsigned Tmo0Cycles = TimeoutUs0 * ClkMhz,
   parameter int unsigned Tmo1Cycles = TimeoutUs1 * ClkMhz,
   parameter int unsigned Tmo2Cycles = TimeoutUs2 * ClkMhz,
   parameter int unsigned Tmo3Cycles = TimeoutUs3 * ClkMhz,
   parameter int unsigned RampCycles = PwrUpCycles
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic phyMicrocontrollerHealthy,
   output logic auxStart,
   output logic auxRouteTunnel,
   input wire logic auxReplyValid,
   input wire logic auxReplyError,
   input wire logic [31:0] auxReplyWord,
   input wire logic [2:0] auxReplyIndex,
   output logic auxIoPowered,
   output logic deepLowPowerAllowed,
   output logic transactionDone
);
   typedef enum logic [1:0] {
      AuxIdle = 2'b00,
      AuxWait = 2'b01
   } aux_state_e;

   function automatic logic [31:0] tmoCycles(input logic [1:0] code);
      unique case (code)
         2'b00: tmoCycles = 32'(Tmo0Cycles);
         2'b01: tmoCycles = 32'(Tmo1Cycles);
         2'b10: tmoCycles = 32'(Tmo2Cycles);
         2'b11: tmoCycles = 32'(Tmo3Cycles);
      endcase
   endfunction

   // payload window: five aligned words after the control word
   function automatic logic isDataAddr(input logic [11:0] a);
      isDataAddr = a >= OffData0 && a < OffData0 + 12'(4 * NumData) && a[1:0] == 2'b00;
   endfunction

   aux_pwr_if pwrBus();
   aux_pwr_seq #(.RampCycles(RampCycles)) uPwr (
      .clk(clk),
      .rst_n(rst_n),
      .pwr(pwrBus)
   );

   aux_state_e state_q, state_d;
   logic [31:0] ctl_q, ctl_d;
   logic [31:0] data_q [NumData];
   logic [31:0] data_d [NumData];
   logic [31:0] tmr_q, tmr_d;
   logic pwrFw_q, pwrFw_d, pwrDrv_q, pwrDrv_d, lowPwr_q, lowPwr_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d, start_d;
   logic wrEn, rdEn, hit;
   logic [11:0] dOff;
   logic replyWord, replyEnd;

   assign wrEn = psel && penable && pwrite && !pready;
   assign rdEn = psel && penable && !pwrite && !pready;
   // either requester keeps the io up; releasing one never forces it down
   assign pwrBus.request = pwrFw_q | pwrDrv_q;
   // index 5 is the end marker; indices 0 to 4 fill the payload
   assign replyWord = auxReplyValid && auxReplyIndex < 3'(NumData);
   assign replyEnd = auxReplyValid && auxReplyIndex == 3'(NumData);

   always_comb begin
      state_d = state_q;
      ctl_d = ctl_q;
      data_d = data_q;
      tmr_d = tmr_q;
      pwrFw_d = pwrFw_q;
      pwrDrv_d = pwrDrv_q;
      lowPwr_d = lowPwr_q;
      start_d = 1'b0;
      prdata_d = 32'h0000_0000;
      // one wait state: answers are registered, so every access takes three cycles, setup included
      pready_d = psel && penable && !pready;
      pslverr_d = 1'b0;
      hit = 1'b1;
      dOff = paddr - OffData0;
      if (wrEn) begin
         if (paddr == OffCtl) begin
            // configuration only changes while idle
            if (state_q == AuxIdle) begin
               ctl_d[BitRoute] = pwdata[BitRoute];
               ctl_d[BitIrqEn] = pwdata[BitIrqEn];
               ctl_d[TmoLsb +: 2] = pwdata[TmoLsb +: 2];
               ctl_d[23:0] = pwdata[23:0];
               if (pwdata[BitBusy]) begin
                  ctl_d[BitBusy] = 1'b1;
                  state_d = AuxWait;
                  // counter loads here so the timeout runs from the start edge
                  tmr_d = tmoCycles(pwdata[TmoLsb +: 2]);
                  start_d = 1'b1;
               end
            end
            // status clears work while busy so a stale flag can be dropped at any time
            if (pwdata[BitDone]) ctl_d[BitDone] = 1'b0;
            if (pwdata[BitRxErr]) ctl_d[BitRxErr] = 1'b0;
         end else if (isDataAddr(paddr)) begin
            if (state_q == AuxIdle) data_d[dOff[4:2]] = pwdata;
         end else if (paddr == OffPwrFw) begin
            pwrFw_d = pwdata[0];
         end else if (paddr == OffPwrDrv) begin
            pwrDrv_d = pwdata[0];
         end else if (paddr == OffLowPwr) begin
            lowPwr_d = pwdata[0];
         end else begin
            hit = 1'b0;
         end
      end
      if (rdEn) begin
         if (paddr == OffCtl) begin
            prdata_d = ctl_q;
         end else if (isDataAddr(paddr)) begin
            prdata_d = data_q[dOff[4:2]];
         end else if (paddr == OffPwrFw) begin
            prdata_d = {31'h0000_0000, pwrFw_q};
         end else if (paddr == OffPwrDrv) begin
            prdata_d = {31'h0000_0000, pwrDrv_q};
         end else if (paddr == OffPwrStat) begin
            prdata_d = 32'h0000_0000;
            prdata_d[0] = pwrBus.powered;
            prdata_d[BitHealth] = phyMicrocontrollerHealthy;
         end else if (paddr == OffLowPwr) begin
            prdata_d = {31'h0000_0000, lowPwr_q};
         end else begin
            hit = 1'b0;
         end
      end
      // unmapped or unaligned offsets: error, write dropped, read as zero
      if ((wrEn || rdEn) && !hit) pslverr_d = 1'b1;
      if (state_q == AuxWait) begin
         // reply and timeout set done in the same cycle busy drops; they beat a software clear
         if (replyWord) begin
            data_d[auxReplyIndex] = auxReplyWord;
         end
         if (replyEnd) begin
            ctl_d[BitBusy] = 1'b0;
            ctl_d[BitDone] = 1'b1;
            if (auxReplyError) ctl_d[BitRxErr] = 1'b1;
            state_d = AuxIdle;
            // a silent sink ends on the timeout, so busy can never hang
         end else if (tmr_q <= 32'h0000_0001) begin
            ctl_d[BitBusy] = 1'b0;
            ctl_d[BitDone] = 1'b1;
            state_d = AuxIdle;
         end else begin
            tmr_d = tmr_q - 32'h0000_0001;
         end
      end
   end

   // every output except auxIoPowered is registered from the same next values as the state; auxIoPowered copies pwrBus.powered one cycle late
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= AuxIdle;
         ctl_q <= CtlReset;
         for (int i = 0; i < NumData; i++) data_q[i] <= 32'h0000_0000;
         tmr_q <= 32'h0000_0000;
         pwrFw_q <= 1'b0;
         pwrDrv_q <= 1'b0;
         lowPwr_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         auxStart <= 1'b0;
         auxRouteTunnel <= 1'b0;
         auxIoPowered <= 1'b0;
         deepLowPowerAllowed <= 1'b0;
         transactionDone <= 1'b0;
      end else begin
         state_q <= state_d;
         ctl_q <= ctl_d;
         data_q <= data_d;
         tmr_q <= tmr_d;
         pwrFw_q <= pwrFw_d;
         pwrDrv_q <= pwrDrv_d;
         lowPwr_q <= lowPwr_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         auxStart <= start_d;
         auxRouteTunnel <= ctl_d[BitRoute];
         auxIoPowered <= pwrBus.powered;
         deepLowPowerAllowed <= lowPwr_d;
         transactionDone <= ctl_d[BitDone] & ctl_d[BitIrqEn];
      end
   end
endmodule

/* dv/aux_props.sv */
// port checker for the aux channel controller
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module aux_props
   import aux_pkg::*;
#(
   parameter int unsigned RampCycles = PwrUpCycles
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic auxStart,
   input wire logic auxRouteTunnel,
   input wire logic auxReplyValid,
   input wire logic auxReplyError,
   input wire logic [2:0] auxReplyIndex,
   input wire logic auxIoPowered,
   input wire logic deepLowPowerAllowed,
   input wire logic transactionDone
);
   localparam int RampW = RampCycles + 6;
   logic busyQ;
   logic busyD;
   wire acc = psel && penable && pready;
   wire ctlWr = acc && pwrite && paddr == OffCtl;
   // timeouts are invisible here, so a read showing idle also ends busy
   always_comb begin
      busyD = busyQ;
      if (auxReplyValid && auxReplyIndex == 3'h5) busyD = 1'b0;
      if (acc && !pwrite && paddr == OffCtl && !prdata[BitBusy]) busyD = 1'b0;
      if (auxStart) busyD = 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busyQ <= 1'b0;
      else busyQ <= busyD;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_err: assert property (acc && paddr > OffLowPwr |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_start_taken: assert property (ctlWr && pwdata[BitBusy] && !busyQ |-> auxStart)
      else $error("start write did not launch");
   a_start_ignored: assert property (ctlWr && busyQ |-> !auxStart)
      else $error("start accepted while busy");
   a_start_pulse: assert property (auxStart |=> !auxStart)
      else $error("start longer than one cycle");
   a_route_follow: assert property (ctlWr && !busyQ |=> auxRouteTunnel == $past(pwdata[BitRoute]))
      else $error("route does not follow control write");
   a_lowpwr_follow: assert property (acc && pwrite && paddr == OffLowPwr |=> deepLowPowerAllowed == $past(pwdata[0]))
      else $error("low power select not stored");
   a_power_ramp: assert property (acc && pwrite && paddr == OffPwrFw && pwdata[0] |-> ##[1:RampW] auxIoPowered)
      else $error("io power not up after request");
   c_err_end: cover property (auxReplyValid && auxReplyIndex == 3'h5 && auxReplyError);
   c_busy_write: cover property (ctlWr && busyQ);
   c_done: cover property ($rose(transactionDone));
endmodule

bind aux_channel_controller aux_props #(.RampCycles(RampCycles)) props (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .auxStart(auxStart),
   .auxRouteTunnel(auxRouteTunnel), .auxReplyValid(auxReplyValid), .auxReplyError(auxReplyError),
   .auxReplyIndex(auxReplyIndex), .auxIoPowered(auxIoPowered), .deepLowPowerAllowed(deepLowPowerAllowed),
   .transactionDone(transactionDone)
);

/* dv/aux_sink_model.sv */
// far-side sink: answers a start with five words and an end marker
// assumes mode is set before the start; 1 = error end only, 2 = silent
`timescale 1ns/1ps
module aux_sink_model (
   input wire logic clk,
   input wire logic auxStart,
   input wire logic [1:0] mode,
   output logic auxReplyValid,
   output logic auxReplyError,
   output logic [31:0] auxReplyWord,
   output logic [2:0] auxReplyIndex
);
   initial begin
      auxReplyValid = 1'b0;
      auxReplyError = 1'b0;
      auxReplyWord = 32'h0000_0000;
      auxReplyIndex = 3'h7;
      forever begin
         @(posedge clk);
         if (auxStart) begin
            repeat (20) @(posedge clk);
            for (int i = (mode == 2'd1) ? 5 : 0; i < 6 && mode != 2'd2; i++) begin
               auxReplyValid <= 1'b1;
               auxReplyIndex <= 3'(i);
               auxReplyWord <= 32'hC0DE_0000 + 32'(i);
               auxReplyError <= mode == 2'd1;
               @(posedge clk);
            end
            // idle word flips so a stale capture shows
            auxReplyValid <= 1'b0;
            auxReplyWord <= ~auxReplyWord;
         end
      end
   end
endmodule

/* dv/aux_tb.sv */
// bench: apb tasks, power, transfer, error and timeout tests
// assumes short timeout counts and the sink model on the reply side
`timescale 1ns/1ps
module testbench;
   import aux_pkg::*;
   localparam int T[4] = '{40, 60, 80, 120};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, phyMicrocontrollerHealthy, auxStart;
   logic auxRouteTunnel, auxReplyValid, auxReplyError, auxIoPowered, deepLowPowerAllowed, transactionDone;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, auxReplyWord, rd;
   logic [2:0] auxReplyIndex;
   logic [1:0] mode;
   logic er;
   int n_errors, n_tests, cyc, dt;
   aux_channel_controller #(.Tmo0Cycles(T[0]), .Tmo1Cycles(T[1]), .Tmo2Cycles(T[2]), .Tmo3Cycles(T[3]),
      .RampCycles(4)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phyMicrocontrollerHealthy(phyMicrocontrollerHealthy), .auxStart(auxStart),
      .auxRouteTunnel(auxRouteTunnel), .auxReplyValid(auxReplyValid), .auxReplyError(auxReplyError),
      .auxReplyWord(auxReplyWord), .auxReplyIndex(auxReplyIndex), .auxIoPowered(auxIoPowered),
      .deepLowPowerAllowed(deepLowPowerAllowed), .transactionDone(transactionDone)
   );
   aux_sink_model sink (
      .clk(clk), .auxStart(auxStart), .mode(mode), .auxReplyValid(auxReplyValid),
      .auxReplyError(auxReplyError), .auxReplyWord(auxReplyWord), .auxReplyIndex(auxReplyIndex)
   );
   always @(posedge clk) cyc <= cyc + 1;
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_idle(output int d);
      int t0;
      t0 = cyc;
      do apb(1'b0, OffCtl, 32'h0000_0000); while (rd[BitBusy] === 1'b1 && cyc - t0 < 3000);
      d = cyc - t0;
   endtask
   task automatic finish_test;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test;
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, mode} = '0;
      phyMicrocontrollerHealthy = 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, OffCtl, 32'h0000_0000);
      chk(rd, CtlReset);
      apb(1'b1, OffPwrFw, 32'h0000_0001);
      do apb(1'b0, OffPwrStat, 32'h0000_0000); while (rd[0] !== 1'b1 && cyc < 1000);
      chk(rd, 32'h0000_8001);
      apb(1'b1, OffPwrDrv, 32'h0000_0001);
      apb(1'b1, OffPwrFw, 32'h0000_0000);
      repeat (10) @(posedge clk);
      chk(32'(auxIoPowered), 32'h0000_0001);
      apb(1'b1, OffPwrDrv, 32'h0000_0000);
      repeat (1000) @(posedge clk);
      chk(32'(auxIoPowered), 32'h0000_0000);
      phyMicrocontrollerHealthy <= 1'b0;
      apb(1'b0, OffPwrStat, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      phyMicrocontrollerHealthy <= 1'b1;
      apb(1'b1, OffLowPwr, 32'h0000_0001);
      chk(32'(deepLowPowerAllowed), 32'h0000_0001);
      apb(1'b1, OffLowPwr, 32'h0000_0000);
      chk(32'(deepLowPowerAllowed), 32'h0000_0000);
      apb(1'b1, OffPwrDrv, 32'h0000_0001);
      do apb(1'b0, OffPwrStat, 32'h0000_0000); while (rd[0] !== 1'b1 && cyc < 3000);
      chk(rd, 32'h0000_8001);
      apb(1'b0, 12'h030, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      for (int i = 0; i < 5; i++) apb(1'b1, OffData0 + 12'(4 * i), 32'h1100_0000 + 32'(i));
      apb(1'b0, OffData0 + 12'h010, 32'h0000_0000);
      chk(rd, 32'h1100_0004);
      apb(1'b1, OffCtl, 32'hA500_0000);
      wait_idle(dt);
      chk(rd, 32'h6500_0000);
      chk(32'(transactionDone), 32'h0000_0001);
      chk(32'(auxRouteTunnel), 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, OffData0 + 12'(4 * i), 32'h0000_0000);
         chk(rd, 32'hC0DE_0000 + 32'(i));
      end
      apb(1'b1, OffCtl, 32'h4000_0000);
      apb(1'b0, OffCtl, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(transactionDone), 32'h0000_0000);
      mode = 2'd1;
      apb(1'b1, OffCtl, 32'h8000_0000);
      apb(1'b1, OffData0, 32'hDEAD_0000);
      apb(1'b1, OffCtl, 32'h8100_0000);
      wait_idle(dt);
      chk(rd, 32'h4200_0000);
      apb(1'b0, OffData0, 32'h0000_0000);
      chk(rd, 32'hC0DE_0000);
      apb(1'b1, OffCtl, 32'h4200_0000);
      apb(1'b0, OffCtl, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      mode = 2'd2;
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, OffCtl, 32'h8000_0000 | (32'(c) << TmoLsb));
         wait_idle(dt);
         chk(32'(dt >= T[c] - 3 && dt <= T[c] + 9), 32'h0000_0001);
         chk(rd, 32'h4000_0000 | (32'(c) << TmoLsb));
         apb(1'b1, OffCtl, 32'h4000_0000);
      end
      finish_test;
   end
endmodule
